// [design/cid_caller_match_block.sv]
// caller match block: modem notification parser, ring guard, number compare, apb registers
// Function
// [R1] count modem RING notifications, then take caller number from +CLIP line
// [R2] without wildcard, match needs equal length and identical characters
// [R3] output goes on only on match while operate input is high
// [R4] operate input low holds the output unchanged
// [R5] clear input forces the output off
// [R6] retention option restores the output state after power loss
// [R7] stored number up to 28 characters from plus comma minus star digits
// [R8] one ring count setting, limited to 1 through 20
// [R9] trailing star matches the prefix plus at least one further character
// [R10] lone star matches anyone, plus star matches international numbers
// [R11] detection suspended 15 seconds after the last RING
// [R12] rings counted as notifications, not audible tones
// [R13] block never answers the call
// [R14] modem must be set by the host to auto answer for maintenance
// [R15] lower auto answer count brings detection forward to that count
// [R16] equal counts detect and answer together, lower detect count detects first
// [R17] ring counter cleared when the guard time expires
// [R18] comparison evaluated once per call at the threshold
`timescale 1ns/1ps
`include "cid_defines.svh"
module cid_caller_match_block
  import cid_pkg::*;
#(
  parameter int unsigned NUM_CHARS    = 32'(`CID_NUM_MAX),
  parameter int unsigned GUARD_CYCLES = 32'(`CID_GUARD_CYCLES)
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // modem byte stream
  input  wire cid_rx_type  modem_rx,
  // block inputs
  input  wire logic        op_enable,
  input  wire logic        clear_in,
  // retention store
  input  wire logic        restore,
  input  wire logic        saved_state,
  output logic             save_state,
  // block output
  output logic             match_out
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic             retain_reg,  retain_next;
  cid_ring_cfg_type cfg_reg,     cfg_next;
  logic [4:0]       len_reg,     len_next;
  logic [31:0]      prdata_reg,  prdata_next;
  logic             pready_reg,  pready_next;
  logic             pslverr_reg, pslverr_next;
  logic [7:0]       num_mem   [NUM_CHARS];
  logic [7:0]       caller_mem[NUM_CHARS];
  cid_state_type    st_reg,      st_next;
  logic [3:0]       pidx_reg,    pidx_next;
  logic [4:0]       clen_reg,    clen_next;
  logic [31:0]      guard_reg,   guard_next;
  logic [4:0]       rcnt_reg,    rcnt_next;
  logic             done_reg,    done_next;
  logic             last_reg,    last_next;
  logic             out_reg,     out_next;
  logic             save_reg,    save_next;
  // decode and strobes
  logic             hit, num_sel, num_we, cwe;
  logic [4:0]       num_idx;
  logic [11:0]      num_off;
  logic [31:0]      rdata;
  logic             ring_evt, clip_evt, eval, expire, match, wild, len_ok;
  logic [4:0]       thr, prefix;
  logic [NUM_CHARS-1:0] cell_ok;
  logic [7:0]       ch;
  // notification texts held as constants, since a literal cannot be part-selected
  localparam logic [31:0] RING_TXT = `CID_STR_RING;
  localparam logic [63:0] CLIP_TXT = `CID_STR_CLIP;

  // allowed characters of the stored number
  function automatic logic valid_char(input logic [7:0] c);
    valid_char = (c == `CID_CH_PLUS) || (c == `CID_CH_COMMA) || (c == `CID_CH_MINUS) ||
                 (c == `CID_CH_STAR) || ((c >= `CID_CH_ZERO) && (c <= `CID_CH_NINE));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb address decode and read mux
  always_comb begin
    hit     = 1'b1;
    num_sel = 1'b0;
    num_off = paddr - `CID_OFF_NUM;
    num_idx = num_off[6:2];
    rdata   = 32'h0000_0000;
    if (paddr == `CID_OFF_CTRL) begin
      rdata[`CID_CTRL_RETAIN] = retain_reg;
    end else if (paddr == `CID_OFF_RING) begin
      rdata[`CID_RING_DET_LSB +: 5]  = cfg_reg.det_cnt;
      rdata[`CID_RING_AUTO_LSB +: 5] = cfg_reg.auto_cnt;
    end else if (paddr == `CID_OFF_LEN) begin
      rdata[4:0] = len_reg;
    end else if (paddr == `CID_OFF_STAT) begin
      rdata[`CID_STAT_OUT]            = out_reg;
      rdata[`CID_STAT_GUARD]          = (guard_reg != 32'h0000_0000);
      rdata[`CID_STAT_DONE]           = done_reg;
      rdata[`CID_STAT_LAST]           = last_reg;
      rdata[`CID_STAT_RCNT_LSB +: 5]  = rcnt_reg;
      rdata[`CID_STAT_CLEN_LSB +: 5]  = clen_reg;
    end else if ((paddr >= `CID_OFF_NUM) && (paddr <= `CID_OFF_NUM_END) &&
                 (paddr[1:0] == 2'b00)) begin
      num_sel    = 1'b1;
      rdata[7:0] = num_mem[num_idx];
    end else begin
      hit = 1'b0;
    end
  end

  // apb answer one cycle into the access phase; writes land on the pready edge
  always_comb begin
    retain_next  = retain_reg;
    cfg_next     = cfg_reg;
    len_next     = len_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    num_we       = 1'b0;
    if (psel && penable && !pready_reg) begin
      pready_next  = 1'b1;
      pslverr_next = !hit;
      if (!pwrite) begin
        prdata_next = hit ? rdata : 32'h0000_0000;
      end
    end
    if (psel && penable && pready_reg && pwrite && hit) begin
      if (paddr == `CID_OFF_CTRL) begin
        retain_next = pwdata[`CID_CTRL_RETAIN];
      end else if (paddr == `CID_OFF_RING) begin
        // an out of range detect count clamps into 1..20; the auto answer count is taken as written
        cfg_next.det_cnt  = pwdata[`CID_RING_DET_LSB +: 5];               // [R8]
        if (pwdata[`CID_RING_DET_LSB +: 5] < `CID_RING_MIN) begin
          cfg_next.det_cnt = `CID_RING_MIN;                                 // [R8]
        end else if (pwdata[`CID_RING_DET_LSB +: 5] > `CID_RING_MAX) begin
          cfg_next.det_cnt = `CID_RING_MAX;                                 // [R8]
        end
        cfg_next.auto_cnt = pwdata[`CID_RING_AUTO_LSB +: 5];
      end else if (paddr == `CID_OFF_LEN) begin
        if ((pwdata[31:5] == 27'h000_0000) && (pwdata[4:0] <= 5'(NUM_CHARS))) begin
          len_next = pwdata[4:0];                                           // [R7]
        end
      end else if (num_sel) begin
        num_we = valid_char(pwdata[7:0]) && (pwdata[31:8] == 24'h00_0000); // [R7]
      end
    end
  end

  // apb and configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      retain_reg  <= 1'b0;
      cfg_reg     <= '{auto_cnt: 5'h00, det_cnt: `CID_RST_DET};
      len_reg     <= 5'h00;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      for (int i = 0; i < NUM_CHARS; i++) begin
        num_mem[i] <= 8'h00;
      end
    end else begin
      retain_reg  <= retain_next;
      cfg_reg     <= cfg_next;
      len_reg     <= len_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      if (num_we) begin
        num_mem[num_idx] <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // notification parser: RING lines and the quoted number of +CLIP lines
  always_comb begin
    st_next   = st_reg;
    pidx_next = pidx_reg;
    clen_next = clen_reg;
    ring_evt  = 1'b0;
    clip_evt  = 1'b0;
    cwe       = 1'b0;
    ch        = modem_rx.data;
    if (modem_rx.valid) begin
      case (st_reg)
        CID_ST_LINE: begin
          pidx_next = 4'h1;
          if (ch == RING_TXT[31:24]) begin
            st_next = CID_ST_RING;
          end else if (ch == CLIP_TXT[63:56]) begin
            st_next = CID_ST_HDR;
          end else if ((ch != `CID_CH_CR) && (ch != `CID_CH_LF)) begin
            st_next = CID_ST_SKIP;
          end
        end
        CID_ST_RING: begin
          if (ch != RING_TXT[8 * (`CID_LEN_RING - 4'h1 - pidx_reg) +: 8]) begin
            st_next = CID_ST_SKIP;
          end else if (pidx_reg == `CID_LEN_RING - 4'h1) begin
            ring_evt = 1'b1;                                                // [R12]
            st_next  = CID_ST_SKIP;
          end else begin
            pidx_next = pidx_reg + 4'h1;
          end
        end
        CID_ST_HDR: begin
          if (ch != CLIP_TXT[8 * (`CID_LEN_CLIP - 4'h1 - pidx_reg) +: 8]) begin
            st_next = CID_ST_SKIP;
          end else if (pidx_reg == `CID_LEN_CLIP - 4'h1) begin
            clen_next = 5'h00;
            st_next   = CID_ST_NUM;
          end else begin
            pidx_next = pidx_reg + 4'h1;
          end
        end
        CID_ST_NUM: begin
          // characters past the store only count, so long callers never equal
          if (ch == `CID_CH_QUOTE) begin
            clip_evt = 1'b1;                                                // [R1]
            st_next  = CID_ST_SKIP;
          end else if ((ch == `CID_CH_CR) || (ch == `CID_CH_LF)) begin
            st_next = CID_ST_LINE;
          end else begin
            cwe = (clen_reg < 5'(NUM_CHARS));                               // [R1]
            if (clen_reg != `CID_CNT_SAT) begin
              clen_next = clen_reg + 5'h01;
            end
          end
        end
        CID_ST_SKIP: begin
          if (ch == `CID_CH_LF) begin
            st_next = CID_ST_LINE;
          end
        end
        default: begin
          st_next = CID_ST_SKIP;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparison of the caller with the stored number
  always_comb begin
    wild   = (len_reg != 5'h00) && (num_mem[5'(len_reg - 5'h01)] == `CID_CH_STAR); // [R9]
    prefix = wild ? 5'(len_reg - 5'h01) : len_reg;
    len_ok = wild ? (clen_reg >= len_reg) : (clen_reg == len_reg);         // [R2] [R9] [R10]
    match  = (len_reg != 5'h00) && len_ok && (&cell_ok);                   // [R2]
  end

  // one compare cell per stored position
  for (genvar g = 0; g < NUM_CHARS; g++) begin : g_cell
    cid_char_cmp #(
      .POS (5'(g))
    ) u_cmp (
      .stored_char (num_mem[g]),
      .caller_char (caller_mem[g]),
      .prefix_len  (prefix),
      .ok          (cell_ok[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // ring count, guard time, single evaluation and the output bit
  always_comb begin
    // an earlier modem answer pulls detection forward; the block itself never answers
    thr = ((cfg_reg.auto_cnt != 5'h00) && (cfg_reg.auto_cnt < cfg_reg.det_cnt)) ?
          cfg_reg.auto_cnt : cfg_reg.det_cnt;                                  // [R15] [R16] [R13]
    expire     = (guard_reg == 32'h0000_0001);
    guard_next = guard_reg;
    rcnt_next  = rcnt_reg;
    if (ring_evt) begin
      guard_next = GUARD_CYCLES;                                               // [R11]
      if (rcnt_reg != `CID_CNT_SAT) begin
        rcnt_next = rcnt_reg + 5'h01;                                          // [R1]
      end
    end else if (guard_reg != 32'h0000_0000) begin
      guard_next = guard_reg - 32'h0000_0001;
      if (expire) begin
        rcnt_next = 5'h00;                                                     // [R17]
      end
    end
    eval      = clip_evt && !done_reg && (rcnt_reg >= thr);                    // [R18] [R8]
    done_next = eval ? 1'b1 : (expire ? 1'b0 : done_reg);                      // [R11] [R18]
    last_next = eval ? match : last_reg;
    out_next  = out_reg;
    if (clear_in) begin
      out_next = 1'b0;                                                         // [R5]
    end else if (restore) begin
      out_next = retain_reg && saved_state;                                    // [R6]
    end else if (eval && op_enable && match) begin
      out_next = 1'b1;                                                         // [R3]
    end
    // with clear and restore low, operate low leaves out_next at out_reg [R4]
    save_next = retain_reg && out_reg;                                         // [R6]
  end

  // parser, call and output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg    <= CID_ST_LINE;
      pidx_reg  <= 4'h0;
      clen_reg  <= 5'h00;
      guard_reg <= 32'h0000_0000;
      rcnt_reg  <= 5'h00;
      done_reg  <= 1'b0;
      last_reg  <= 1'b0;
      out_reg   <= 1'b0;
      save_reg  <= 1'b0;
      for (int i = 0; i < NUM_CHARS; i++) begin
        caller_mem[i] <= 8'h00;
      end
    end else begin
      st_reg    <= st_next;
      pidx_reg  <= pidx_next;
      clen_reg  <= clen_next;
      guard_reg <= guard_next;
      rcnt_reg  <= rcnt_next;
      done_reg  <= done_next;
      last_reg  <= last_next;
      out_reg   <= out_next;
      save_reg  <= save_next;
      if (cwe) begin
        caller_mem[clen_reg] <= ch;
      end
    end
  end

  // outputs straight from flops
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign save_state = save_reg;
  assign match_out  = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_clear;
    clear_in |=> !match_out;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not force output off"); // [R5]

  property p_hold;
    !op_enable && !clear_in && !restore |=> $stable(match_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while operate low"); // [R4]

  property p_set_cause;
    $rose(match_out) |-> $past(eval && op_enable && match) || $past(restore && retain_reg);
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("output set without cause"); // [R3]

  property p_once;
    eval |=> done_reg ##0 !eval;
  endproperty
  a_once: assert property (p_once) else $error("second evaluation in one call"); // [R18]

  property p_guard;
    ring_evt |=> (guard_reg == GUARD_CYCLES) ##1 (guard_reg == GUARD_CYCLES - 1 || ring_evt);
  endproperty
  a_guard: assert property (p_guard) else $error("guard not reloaded by ring"); // [R11]

  property p_thr;
    eval |-> (rcnt_reg >= thr) && (thr >= `CID_RING_MIN) && (thr <= cfg_reg.det_cnt);
  endproperty
  a_thr: assert property (p_thr) else $error("evaluation before threshold"); // [R15]

  property p_det_range;
    (cfg_reg.det_cnt >= `CID_RING_MIN) && (cfg_reg.det_cnt <= `CID_RING_MAX);
  endproperty
  a_det_range: assert property (p_det_range) else $error("ring count out of range"); // [R8]

  property p_len;
    len_reg <= 5'(NUM_CHARS);
  endproperty
  a_len: assert property (p_len) else $error("stored length above limit"); // [R7]

  property p_exact;
    !wild && (clen_reg != len_reg) |-> !match;
  endproperty
  a_exact: assert property (p_exact) else $error("length mismatch matched"); // [R2]

  property p_wild;
    wild && (clen_reg < len_reg) |-> !match;
  endproperty
  a_wild: assert property (p_wild) else $error("wildcard matched a short caller"); // [R9]

  property p_expire;
    expire && !ring_evt |=> (rcnt_reg == 5'h00) && (guard_reg == 32'h0000_0000);
  endproperty
  a_expire: assert property (p_expire) else $error("counter kept after guard"); // [R17]

  c_match:   cover property (eval && match && op_enable);
  c_nomatch: cover property (eval && !match);
  c_expire:  cover property (expire);
  c_restore: cover property (restore && retain_reg && saved_state);
endmodule

// [design/cid_char_cmp.sv]
// one position of the stored versus caller number comparison
`timescale 1ns/1ps
module cid_char_cmp #(
  parameter logic [4:0] POS = 5'h00
) (
  // characters
  input  wire logic [7:0] stored_char,
  input  wire logic [7:0] caller_char,
  // compare window
  input  wire logic [4:0] prefix_len,
  output logic            ok
);
  // positions past the prefix are free
  assign ok = (POS >= prefix_len) || (stored_char == caller_char);
endmodule

// [design/cid_defines.svh]
// register offsets, field positions, reset values, characters and timing of the caller match
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH

// register byte offsets
`define CID_OFF_CTRL      12'h000
`define CID_OFF_RING      12'h004
`define CID_OFF_LEN       12'h008
`define CID_OFF_STAT      12'h00C
`define CID_OFF_NUM       12'h040
`define CID_OFF_NUM_END   12'h0AC

// field positions
`define CID_CTRL_RETAIN   0
`define CID_RING_DET_LSB  0
`define CID_RING_AUTO_LSB 8
`define CID_STAT_OUT      0
`define CID_STAT_GUARD    1
`define CID_STAT_DONE     2
`define CID_STAT_LAST     3
`define CID_STAT_RCNT_LSB 8
`define CID_STAT_CLEN_LSB 16

// limits and reset values
`define CID_RST_DET       5'h01
`define CID_RING_MIN      5'h01
`define CID_RING_MAX      5'h14
`define CID_CNT_SAT       5'h1F
`define CID_NUM_MAX       5'h1C

// characters
`define CID_CH_PLUS       8'h2B
`define CID_CH_COMMA      8'h2C
`define CID_CH_MINUS      8'h2D
`define CID_CH_STAR       8'h2A
`define CID_CH_ZERO       8'h30
`define CID_CH_NINE       8'h39
`define CID_CH_QUOTE      8'h22
`define CID_CH_CR         8'h0D
`define CID_CH_LF         8'h0A
`define CID_STR_RING      32'h5249_4E47
`define CID_STR_CLIP      64'h2B43_4C49_503A_2022
`define CID_LEN_RING      4'h4
`define CID_LEN_CLIP      4'h8

// timing: guard time in seconds and clock rate in hertz
`define CID_GUARD_S       64'h0000_0000_0000_000F
`define CID_CLK_HZ        64'h0000_0000_05F5_E100
`define CID_GUARD_CYCLES  (`CID_GUARD_S * `CID_CLK_HZ)

`endif

// [design/cid_pkg.sv]
// types shared by the caller match design
package cid_pkg;
  typedef enum logic [4:0] {
    CID_ST_LINE = 5'b0_0001,
    CID_ST_RING = 5'b0_0010,
    CID_ST_HDR  = 5'b0_0100,
    CID_ST_NUM  = 5'b0_1000,
    CID_ST_SKIP = 5'b1_0000
  } cid_state_type;

  typedef struct packed {
    logic [4:0] auto_cnt;
    logic [4:0] det_cnt;
  } cid_ring_cfg_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cid_rx_type;
endpackage

// [testbench/cid_modem_model.sv]
// behavioural modem that sends ring and caller number notifications
`timescale 1ns/1ps
module cid_modem_model
  import cid_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // auto answer setting of the modem, 0 means never
  input  wire logic [4:0] auto_cnt,
  // notification stream and answer flag
  output cid_rx_type      modem_rx,
  output logic            answered
);
  int unsigned rings;

  initial begin
    modem_rx = '0;
    rings    = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // answers on its own once the ring count reaches the setting
  assign answered = !rst && (auto_cnt != 5'h00) && (rings >= auto_cnt);

  // one byte a cycle; idle data is inverted so it never looks like a held byte
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      modem_rx <= '{valid: 1'b1, data: s[i]};
    end
    @(posedge clk);
    modem_rx <= '{valid: 1'b0, data: ~s[s.len() - 1]};
  endtask

  // every ring is one notification message, not a heard tone
  task automatic ring();
    send_line("RING\r\n");
    rings++;
  endtask

  task automatic clip(input string num);
    send_line({"+CLIP: \"", num, "\",129\r\n"});
  endtask

  // call ended, next call counts from zero
  task automatic hang_up();
    rings = 0;
  endtask
endmodule

// [testbench/test_cid_caller_match_block.sv]
// self-checking bench of the caller match block with a modem model
`timescale 1ns/1ps
module test_cid_caller_match_block
  import cid_pkg::*;
;
  localparam int unsigned GUARD = 50;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  cid_rx_type  modem_rx;
  logic        op_enable = 1'b0;
  logic        clear_in = 1'b0;
  logic        restore = 1'b0;
  logic        saved_state = 1'b0;
  logic        save_state;
  logic        match_out;
  logic [4:0]  auto_cnt = 5'h00;
  logic        answered;
  logic [31:0] q;
  logic        err;
  int          fails = 0;
  int          n_tests = 0;

  cid_caller_match_block #(.NUM_CHARS(28), .GUARD_CYCLES(GUARD)) i_cid_caller_match_block (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modem_rx(modem_rx), .op_enable(op_enable), .clear_in(clear_in), .restore(restore),
    .saved_state(saved_state), .save_state(save_state), .match_out(match_out));

  cid_modem_model i_cid_modem_model (
    .clk(clk), .rst(rst), .auto_cnt(auto_cnt), .modem_rx(modem_rx), .answered(answered));

  initial begin
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic complete_run();
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; answer taken at the edge where pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      complete_run();
    end
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_num(input string s);
    for (int i = 0; i < s.len(); i++) apb(1'b1, 12'h040 + 12'(4 * i), {24'h00_0000, s[i]});
    apb(1'b1, 12'h008, 32'(s.len()));
  endtask

  task automatic call(input int n, input string num);
    repeat (n) i_cid_modem_model.ring();
    i_cid_modem_model.clip(num);
    @(negedge clk);
  endtask

  // guard time runs out with no ring, so the next call starts fresh
  task automatic end_call();
    repeat (GUARD + 10) @(posedge clk);
    i_cid_modem_model.hang_up();
  endtask

  task automatic pulse_clear();
    @(posedge clk) clear_in <= 1'b1;
    @(posedge clk) clear_in <= 1'b0;
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    apb(1'b0, 12'h004, 32'h0); check(q, 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0); check(q, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0); check({31'h0, err}, 32'h0000_0001);
    check({31'h0, match_out}, 32'h0);
  endtask

  task automatic t_limits();
    apb(1'b1, 12'h004, 32'h0000_0000); apb(1'b0, 12'h004, 32'h0);
    check(q[4:0], 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0015); apb(1'b0, 12'h004, 32'h0);
    check(q[4:0], 32'h0000_0014);
    apb(1'b1, 12'h040, 32'h0000_0031); apb(1'b1, 12'h040, 32'h0000_0041);
    apb(1'b0, 12'h040, 32'h0); check(q, 32'h0000_0031);
    apb(1'b1, 12'h008, 32'h0000_001C); apb(1'b1, 12'h008, 32'h0000_001D);
    apb(1'b0, 12'h008, 32'h0); check(q[4:0], 32'h0000_001C);
  endtask

  task automatic t_call();
    op_enable <= 1'b1;
    apb(1'b1, 12'h004, 32'h0000_0002);
    set_num("123");
    call(1, "123"); check({31'h0, match_out}, 32'h0);
    call(1, "123"); check({31'h0, match_out}, 32'h1);
    pulse_clear(); check({31'h0, match_out}, 32'h0);
    call(1, "123"); check({31'h0, match_out}, 32'h0);
    end_call();
    apb(1'b0, 12'h00C, 32'h0); check({q[12:8], q[2]}, 32'h0);
  endtask

  task automatic t_table();
    string st[9] = '{"123", "123", "123", "123", "12*", "123*", "*", "+*", "+*"};
    string cl[9] = '{"123", "124", "12", "1234", "123", "123", "5", "+49", "49"};
    logic  ex[9] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    apb(1'b1, 12'h004, 32'h0000_0001);
    for (int i = 0; i < 9; i++) begin
      pulse_clear();
      set_num(st[i]);
      call(1, cl[i]);
      check({31'h0, match_out}, {31'h0, ex[i]});
      end_call();
    end
  endtask

  task automatic t_hold();
    pulse_clear();
    @(posedge clk) op_enable <= 1'b0;
    set_num("77");
    call(1, "77"); check({31'h0, match_out}, 32'h0);
    end_call();
    op_enable <= 1'b1;
  endtask

  task automatic t_auto();
    auto_cnt <= 5'h02;
    apb(1'b1, 12'h004, 32'h0000_0205);
    call(2, "77"); check({31'h0, match_out}, 32'h1);
    check({31'h0, answered}, 32'h1);
    end_call();
    pulse_clear();
    apb(1'b1, 12'h004, 32'h0000_0202);
    i_cid_modem_model.ring(); check({31'h0, answered}, 32'h0);
    call(1, "77"); check({answered, match_out}, 32'h3);
    end_call();
    auto_cnt <= 5'h00;
  endtask

  task automatic t_retain();
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (2) @(negedge clk);
    check({31'h0, save_state}, 32'h1);
    pulse_clear();
    @(posedge clk) begin restore <= 1'b1; saved_state <= 1'b1; end
    @(posedge clk) restore <= 1'b0;
    @(negedge clk) check({31'h0, match_out}, 32'h1);
    apb(1'b1, 12'h000, 32'h0000_0000);
    pulse_clear();
    @(posedge clk) restore <= 1'b1;
    @(posedge clk) restore <= 1'b0;
    @(negedge clk) check({31'h0, match_out}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_limits();
    t_call();
    t_table();
    t_hold();
    t_auto();
    t_retain();
    complete_run();
  end
endmodule
